// [design/elpl_pkg.sv]
// shared constants and types for the embosser line packet link
package elpl_pkg;
   localparam int          DOTS_PER_LINE = 40;
   localparam int          IDX_W         = 6;
   localparam logic [7:0]  CH_START      = 8'h21; // '!'
   localparam logic [7:0]  CH_END        = 8'h2a; // '*'
   localparam logic [7:0]  CH_ACK        = 8'h41; // 'A'
   localparam logic [7:0]  CH_ERR        = 8'h45; // 'E'
   localparam logic [7:0]  CH_CANCEL     = 8'h43; // 'C'
   localparam logic [7:0]  CH_EOD        = 8'h04; // end-of-data indicator
   localparam logic [7:0]  CH_EOP        = 8'h0c; // end-of-page indicator

   typedef enum logic [4:0] {
      ELPL_SEND_ACK = 5'b00001,
      ELPL_HUNT     = 5'b00010,
      ELPL_FILL     = 5'b00100,
      ELPL_SEND_ERR = 5'b01000,
      ELPL_DONE     = 5'b10000
   } elpl_state_type;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } elpl_byte_type;

   typedef struct packed {
      logic                  valid;
      logic [IDX_W-1:0]      addr;
      logic [7:0]            data;
   } elpl_wr_type;
endpackage : elpl_pkg

// [design/elpl_line_mem.sv]
// line buffer holding the dot values of one packet
module elpl_line_mem
   import elpl_pkg::*;
(
   input  wire logic                 clock_i,
   input  wire elpl_pkg::elpl_wr_type wr_i,
   input  wire logic [elpl_pkg::IDX_W-1:0] rd_addr_i,
   output logic [7:0]                rd_data_o
);
   logic [7:0] mem [DOTS_PER_LINE];

   always_ff @(posedge clock_i) begin
      if (wr_i.valid) begin
         mem[wr_i.addr] <= wr_i.data;
      end
      rd_data_o <= mem[rd_addr_i];
   end
endmodule // elpl_line_mem

// [design/elpl_link.sv]
// device end of the byte-serial embosser line packet link
module elpl_link
   import elpl_pkg::*;
(
   input  wire logic                     clock_i,
   input  wire logic                     rst_n_i,
   input  wire elpl_pkg::elpl_byte_type  rx_i,
   input  wire logic                     tx_ready_i,
   input  wire logic                     stop_press_i,
   input  wire logic                     cancel_press_i,
   input  wire logic [elpl_pkg::IDX_W-1:0] line_rd_addr_i,
   output elpl_pkg::elpl_byte_type       tx_o,
   output logic                          stop_req_o,
   output logic                          cancel_req_o,
   output logic                          line_ready_o,
   output logic                          page_end_o,
   output logic                          session_end_o,
   output logic [7:0]                    line_rd_data_o
);
   typedef struct packed {
      elpl_state_type   state;
      logic [IDX_W-1:0] count;
      elpl_byte_type    tx;
      elpl_wr_type      wr;
      logic             stop_req;
      logic             cancel_req;
      logic             line_ready;
      logic             page_end;
      logic             session_end;
   } elpl_regs_type;

   // every register cleared except state, which starts in ELPL_SEND_ACK, so the first edge after reset queues the acknowledge
   localparam elpl_regs_type REGS_RESET = '{
      state:       ELPL_SEND_ACK,
      count:       '0,
      tx:          '0,
      wr:          '0,
      stop_req:    1'b0,
      cancel_req:  1'b0,
      line_ready:  1'b0,
      page_end:    1'b0,
      session_end: 1'b0
   };

   elpl_regs_type r;
   elpl_regs_type next_r;
   logic          tx_free;

   elpl_line_mem u_mem (
      .clock_i   (clock_i),
      .wr_i      (r.wr),
      .rd_addr_i (line_rd_addr_i),
      .rd_data_o (line_rd_data_o)
   );

   // a character can be queued once the previous one has been taken
   assign tx_free = !r.tx.valid || tx_ready_i;

   always_comb begin
      next_r = r;
      next_r.wr.valid = 1'b0;
      next_r.page_end = 1'b0;
      if (r.tx.valid && tx_ready_i) begin
         next_r.tx.valid = 1'b0;
      end
      if (stop_press_i) begin
         next_r.stop_req = !r.stop_req;
      end
      case (r.state)
         ELPL_SEND_ACK: begin
            // the page marker follows the end marker at once, so it is caught here too
            if (rx_i.valid && (rx_i.data == CH_EOP)) begin
               next_r.page_end = 1'b1;
            end
            // stopped: the buffered line is kept and the answer waits
            if (tx_free && !r.stop_req) begin
               next_r.tx = '{valid: 1'b1, data: CH_ACK};
               next_r.state = ELPL_HUNT;
               next_r.line_ready = 1'b0;
            end
         end
         ELPL_HUNT: begin
            if (rx_i.valid) begin
               if (rx_i.data == CH_START) begin
                  next_r.state = ELPL_FILL;
                  next_r.count = '0;
               end else if (rx_i.data == CH_EOD) begin
                  next_r.state = ELPL_DONE;
               end else if (rx_i.data == CH_EOP) begin
                  next_r.page_end = 1'b1;
               end
            end
         end
         ELPL_FILL: begin
            if (rx_i.valid) begin
               if (rx_i.data == CH_END) begin
                  next_r.state = ELPL_SEND_ACK;
                  next_r.line_ready = 1'b1;
               end else if (r.count == IDX_W'(DOTS_PER_LINE)) begin
                  next_r.state = ELPL_SEND_ERR;
               end else begin
                  next_r.wr = '{valid: 1'b1, addr: r.count, data: rx_i.data};
                  next_r.count = IDX_W'(r.count + 1'b1);
               end
            end
         end
         ELPL_SEND_ERR: begin
            if (tx_free) begin
               next_r.tx = '{valid: 1'b1, data: CH_ERR};
               next_r.count = '0;
               next_r.state = ELPL_HUNT;
            end
         end
         ELPL_DONE: begin
            if (tx_free && !r.session_end) begin
               next_r.tx = '{valid: 1'b1, data: CH_EOD};
               next_r.session_end = 1'b1;
            end
         end
         default: begin
            next_r.state = ELPL_SEND_ACK;
         end
      endcase
      // cancel overrides everything except page_end: tell the host, restart from the top
      if (cancel_press_i) begin
         next_r.state = ELPL_SEND_ACK;
         next_r.count = '0;
         next_r.wr.valid = 1'b0;
         next_r.stop_req = 1'b0;
         next_r.line_ready = 1'b0;
         next_r.session_end = 1'b0;
         next_r.cancel_req = 1'b1;
         next_r.tx = '{valid: 1'b1, data: CH_CANCEL};
      end else begin
         next_r.cancel_req = 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= REGS_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign tx_o          = r.tx;
   assign stop_req_o    = r.stop_req;
   assign cancel_req_o  = r.cancel_req;
   assign line_ready_o  = r.line_ready;
   assign page_end_o    = r.page_end;
   assign session_end_o = r.session_end;
endmodule // elpl_link

// [dv/elpl_host_model.sv]
// host model pacing the bytes sent by the device
module elpl_host_model
   import elpl_pkg::*;
(
   input  wire logic                    clock_i,
   input  wire logic                    slow_i,
   input  wire elpl_pkg::elpl_byte_type tx_i,
   output logic                         ready_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ready follows valid by a cycle; slow_i stretches the wait on alternate cycles
   always @(posedge clock_i) ready_o <= tx_i.valid & ~(slow_i & ready_o);
endmodule // elpl_host_model

// [dv/elpl_link_sva.sv]
// assertions on the link ports
module elpl_link_sva
   import elpl_pkg::*;
(
   input wire logic clock_i, rst_n_i, tx_ready_i, stop_press_i, cancel_press_i,
   input wire elpl_pkg::elpl_byte_type rx_i, tx_o,
   input wire logic stop_req_o, cancel_req_o, line_ready_o, page_end_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   wire q = !stop_press_i && !cancel_press_i;
   a_reset_ack: assert property (!$past(rst_n_i) |=> tx_o == {1'b1, CH_ACK})
      else $error("no ack");
   a_tx_hold: assert property (tx_o.valid && !tx_ready_i && q |=> $stable(tx_o))
      else $error("tx moved");
   a_line_ack: assert property (line_ready_o && !stop_req_o && q
      |=> tx_o == {1'b1, CH_ACK}) else $error("no ack");
   a_stop_flip: assert property (stop_press_i && !cancel_press_i
      |=> stop_req_o != $past(stop_req_o)) else $error("stop stuck");
   a_cancel_pulse: assert property (cancel_press_i
      |=> cancel_req_o && !stop_req_o ##1 !cancel_req_o) else $error("bad cancel");
   a_cancel_char: assert property (cancel_press_i |=> tx_o == {1'b1, CH_CANCEL})
      else $error("no cancel");
   a_stop_hold: assert property (stop_req_o && line_ready_o && q
      |=> line_ready_o && tx_o != {1'b1, CH_ACK}) else $error("ack while stopped");
   a_page_end: assert property (page_end_o |-> $past(rx_i) == {1'b1, CH_EOP})
      else $error("stray page end");
   cover property (line_ready_o && stop_req_o);
   cover property (tx_o == {1'b1, CH_ERR});
   cover property (cancel_req_o);
endmodule // elpl_link_sva
bind elpl_link elpl_link_sva u_sva (.clock_i, .rst_n_i, .tx_ready_i, .stop_press_i,
   .cancel_press_i, .rx_i, .tx_o, .stop_req_o, .cancel_req_o, .line_ready_o, .page_end_o);

// [dv/elpl_link_tb_top.sv]
// self-checking bench for the link
module elpl_link_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import elpl_pkg::*;
   logic clock_i = 1'b0, rst_n_i = 1'b0, tx_ready_i, stop_req_o, cancel_req_o;
   logic line_ready_o, page_end_o, session_end_o;
   logic [1:0] prs = '0;
   logic [7:0] line_rd_data_o, lb;
   logic [15:0] r = 16'h052f;
   elpl_byte_type rx_i = '0, tx_o;
   int n_errors = 0, checked = 0;
   initial forever #25 clock_i = ~clock_i;
   // read address fixed on the last slot, the edge of the fill count
   elpl_link DUT (.clock_i, .rst_n_i, .rx_i, .tx_ready_i, .stop_press_i(prs[0]),
      .cancel_press_i(prs[1]), .line_rd_addr_i(6'h27), .tx_o, .stop_req_o, .cancel_req_o,
      .line_ready_o, .page_end_o, .session_end_o, .line_rd_data_o);
   elpl_host_model host (.clock_i, .slow_i(r[0]), .tx_i(tx_o), .ready_o(tx_ready_i));
   function automatic logic [15:0] lf(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(bit ok);
      checked++;
      n_errors += int'(!ok);
      if (!ok) $display("FAIL %0t mismatch", $time);
   endtask
   task automatic report_and_stop;
      $display("%0d errors in %0d checks", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic sb(logic [7:0] b);
      @(posedge clock_i) rx_i <= {1'b1, b};
      @(posedge clock_i) rx_i <= '0;
   endtask
   task automatic pkt(int n, bit fin);
      sb(CH_START);
      repeat (n) begin
         lb = r[7:0] == CH_END ? 8'h00 : r[7:0];
         r <= lf(r);
         sb(lb);
      end
      if (fin) sb(CH_END);
   endtask
   task automatic wt(logic [7:0] ch);
      @(negedge clock_i);
      repeat (300) if (!(tx_o.valid && tx_ready_i)) @(negedge clock_i);
      chk(tx_o.valid && tx_ready_i && tx_o.data === ch);
      if (!(tx_o.valid && tx_ready_i)) report_and_stop;
      @(posedge clock_i);
   endtask
   task automatic press(int b);
      @(posedge clock_i) prs[b] <= 1'b1;
      @(posedge clock_i) prs <= '0;
      @(negedge clock_i);
   endtask
   initial begin
      repeat (6) @(posedge clock_i);
      rst_n_i <= 1'b1;
      wt(CH_ACK);
      pkt(40, 1'b1);
      wt(CH_ACK);
      chk(line_rd_data_o === lb);
      pkt(41, 1'b0);
      wt(CH_ERR);
      sb(8'h55);
      pkt(2, 1'b1);
      wt(CH_ACK);
      repeat (3) begin
         pkt(40, 1'b1);
         wt(CH_ACK);
      end
      press(0);
      pkt(3, 1'b1);
      sb(CH_EOP);
      @(negedge clock_i) chk(page_end_o === 1'b1);
      repeat (9) @(negedge clock_i);
      chk(stop_req_o && line_ready_o && tx_o.valid === 1'b0);
      press(0);
      wt(CH_ACK);
      sb(CH_EOP);
      @(negedge clock_i) chk(page_end_o === 1'b1);
      sb(CH_EOD);
      wt(CH_EOD);
      chk(session_end_o === 1'b1);
      press(1);
      chk(cancel_req_o === 1'b1);
      wt(CH_CANCEL);
      wt(CH_ACK);
      report_and_stop;
   end
endmodule // elpl_link_tb_top
